// File: btt_defs.vh
// Constants for the bridge target termination handler.
`ifndef BTT_DEFS_VH
`define BTT_DEFS_VH
// Termination codes reported by the target-bus master.
`define BTT_TERM_NORMAL   3'h0
`define BTT_TERM_RETRY    3'h1
`define BTT_TERM_DISC     3'h2
`define BTT_TERM_TABORT   3'h3
`define BTT_TERM_MABORT   3'h4
// Transaction kinds.
`define BTT_KIND_DWRITE   2'h0
`define BTT_KIND_PWRITE   2'h1
`define BTT_KIND_DREAD    2'h2
// Attempt limit and counter width.
`define BTT_ATTEMPT_LIMIT 25'h1000000
`define BTT_CNT_W         25
// Bus commands.
`define BTT_CMD_MEMWR     4'h7
`define BTT_CMD_MWI       4'hF
// Register offsets.
`define BTT_REG_CTRL      4'h0
`define BTT_REG_STATUS    4'h4
`define BTT_REG_COUNT     4'h8
// Control field positions.
`define BTT_CTRL_SERR_EN  0
`define BTT_CTRL_MA_MODE  1
`define BTT_CTRL_DIS_DW   2
`define BTT_CTRL_DIS_PW   3
`define BTT_CTRL_DIS_DR   4
`define BTT_CTRL_DIS_PTA  5
`define BTT_CTRL_RESET    6'h00
// Status field positions.
`define BTT_ST_RTA        0
`define BTT_ST_STA        1
`define BTT_ST_SERR       2
`define BTT_ST_RMA        3
// All-ones read data after a quiet master abort.
`define BTT_ALL_ONES      32'hFFFFFFFF
`endif

// File: btt_attempt_counter.v
// Attempt counter for one forwarded transaction.
`default_nettype none
`include "btt_defs.vh"
module btt_attempt_counter #(
    parameter [24:0] LIMIT = `BTT_ATTEMPT_LIMIT
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    input  wire        clkEn,
    // Control
    input  wire        clear,
    input  wire        bump,
    // Result
    output wire [24:0] count,
    output wire        atLimit
);
    reg [24:0] count_reg;
    // =========================================================
    // Counter
    // clears on start
    always @(posedge core_clk) begin
        if (reset) begin
            count_reg <= 25'h0000000;
        end else if (clkEn) begin
            if (clear) begin
                count_reg <= 25'h0000000;
            end else if (bump && count_reg != LIMIT) begin
                count_reg <= count_reg + 25'h0000001;
            end
        end
    end
    assign count   = count_reg;
    assign atLimit = (count_reg == LIMIT);
endmodule // btt_attempt_counter
`default_nettype wire

// File: btt_sticky_bits.v
// Sticky status bits with set-over-clear priority.
`default_nettype none
module btt_sticky_bits #(
    parameter W = 4
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         reset,
    input  wire         clkEn,
    // Set and write-one-to-clear
    input  wire [W-1:0] setBits,
    input  wire [W-1:0] clrBits,
    // State
    output wire [W-1:0] bits
);
    reg [W-1:0] bits_reg;
    // =========================================================
    // Status
    always @(posedge core_clk) begin
        if (reset) begin
            bits_reg <= {W{1'b0}};
        end else if (clkEn) begin
            bits_reg <= (bits_reg & ~clrBits) | setBits;
        end
    end
    assign bits = bits_reg;
endmodule // btt_sticky_bits
`default_nettype wire

// File: btt_termination_handler.v
// Target termination handler of a two-sided bus bridge.
//
// Decided for this implementation: the address map and strobed register access.
`default_nettype none
`include "btt_defs.vh"
module btt_termination_handler #(
    parameter [24:0] ATTEMPT_LIMIT = `BTT_ATTEMPT_LIMIT
) (
    // Clock, reset, enable
    input  wire        core_clk,
    input  wire        reset,
    input  wire        clkEn,
    // Register port
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdData,
    // New transaction from the queue
    input  wire        txnStart,
    input  wire [1:0]  txnKind,
    input  wire [31:0] txnAddr,
    input  wire [3:0]  txnCmd,
    input  wire        txnMulti,
    input  wire        txnPrefetch,
    input  wire [7:0]  txnReqDwords,
    // Attempt result from the target-bus master
    input  wire        attemptDone,
    input  wire [2:0]  attemptTerm,
    input  wire [7:0]  attemptDwords,
    input  wire        postedLeft,
    // Reissue request to the target-bus master
    output reg         issueValid,
    output reg  [31:0] issueAddr,
    output reg  [3:0]  issueCmd,
    // Answer to the initiator
    output reg         replyValid,
    output reg         replyRetry,
    output reg         replyDisc,
    output reg         replyAbort,
    output reg         replyTrdy,
    output reg  [31:0] replyData,
    // Initiator repeat of a dropped transaction
    input  wire        initRepeat,
    // Queue drop and system error
    output reg         dropPulse,
    output wire        serrOut
);
    // =========================================================
    // States
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_WAIT  = 3'b010;
    localparam [2:0] ST_DEAD  = 3'b100;

    reg [2:0]  state_reg;
    reg [1:0]  kind_reg;
    reg [31:0] addr_reg;
    reg [3:0]  cmd_reg;
    reg        multi_reg;
    reg        pref_reg;
    reg [7:0]  req_reg;
    reg [5:0]  ctrl_reg;
    reg        serr_reg;

    wire [24:0] attemptCount;
    wire        atLimit;
    reg  [3:0]  stSet;
    wire [3:0]  stClr;
    wire [3:0]  stBits;

    wire isDw = (kind_reg == `BTT_KIND_DWRITE);
    wire isPw = (kind_reg == `BTT_KIND_PWRITE);
    wire isDr = (kind_reg == `BTT_KIND_DREAD);
    wire isRetry = attemptDone && (attemptTerm == `BTT_TERM_RETRY);
    wire wsel = regWrite && (regAddr == `BTT_REG_STATUS);

    assign stClr = wsel ? regWrData[3:0] : 4'h0;
    assign serrOut = serr_reg;

    // Returns the system error enable for the given kind's event.
    function serrAllowed;
        input [5:0] ctrl;
        input [1:0] kind;
        begin
            case (kind)
                `BTT_KIND_DWRITE: serrAllowed = ctrl[`BTT_CTRL_SERR_EN] &
                                                ~ctrl[`BTT_CTRL_DIS_DW];
                `BTT_KIND_PWRITE: serrAllowed = ctrl[`BTT_CTRL_SERR_EN] &
                                                ~ctrl[`BTT_CTRL_DIS_PW];
                default:          serrAllowed = ctrl[`BTT_CTRL_SERR_EN] &
                                                ~ctrl[`BTT_CTRL_DIS_DR];
            endcase
        end
    endfunction

    // =========================================================
    // Submodules
    btt_attempt_counter #(
        .LIMIT    (ATTEMPT_LIMIT)
    ) u_count (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .clear    (txnStart && state_reg != ST_WAIT),
        .bump     (isRetry && state_reg == ST_WAIT),
        .count    (attemptCount),
        .atLimit  (atLimit)
    );

    btt_sticky_bits #(
        .W        (4)
    ) u_status (
        .core_clk (core_clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .setBits  (stSet),
        .clrBits  (stClr),
        .bits     (stBits)
    );

    // =========================================================
    // Control register
    always @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg <= `BTT_CTRL_RESET;
        end else if (clkEn && regWrite && regAddr == `BTT_REG_CTRL) begin
            ctrl_reg <= regWrData[5:0];
        end
    end

    // =========================================================
    // Read port
    always @(posedge core_clk) begin
        if (reset) begin
            regRdData <= 32'h00000000;
        end else if (clkEn) begin
            regRdData <= 32'h00000000;
            if (regRead) begin
                case (regAddr)
                    `BTT_REG_CTRL:   regRdData <= {26'h0, ctrl_reg};
                    `BTT_REG_STATUS: regRdData <= {28'h0, stBits};
                    `BTT_REG_COUNT:  regRdData <= {7'h0, attemptCount};
                    default:         regRdData <= 32'h00000000;
                endcase
            end
        end
    end

    // =========================================================
    // Termination handling
    always @(posedge core_clk) begin
        if (reset) begin
            state_reg  <= ST_IDLE;
            kind_reg   <= `BTT_KIND_DWRITE;
            addr_reg   <= 32'h00000000;
            cmd_reg    <= 4'h0;
            multi_reg  <= 1'b0;
            pref_reg   <= 1'b0;
            req_reg    <= 8'h00;
            issueValid <= 1'b0;
            issueAddr  <= 32'h00000000;
            issueCmd   <= 4'h0;
            replyValid <= 1'b0;
            replyRetry <= 1'b0;
            replyDisc  <= 1'b0;
            replyAbort <= 1'b0;
            replyTrdy  <= 1'b0;
            replyData  <= 32'h00000000;
            dropPulse  <= 1'b0;
            serr_reg   <= 1'b0;
            stSet      <= 4'h0;
        end else if (clkEn) begin
            issueValid <= 1'b0;
            replyValid <= 1'b0;
            replyRetry <= 1'b0;
            replyDisc  <= 1'b0;
            replyAbort <= 1'b0;
            replyTrdy  <= 1'b0;
            dropPulse  <= 1'b0;
            serr_reg   <= 1'b0;
            stSet      <= 4'h0;
            case (state_reg)
                ST_IDLE, ST_DEAD: begin
                    if (state_reg == ST_DEAD && initRepeat) begin
                        replyValid <= 1'b1;
                        replyAbort <= 1'b1;
                        stSet[`BTT_ST_STA] <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (txnStart) begin
                        kind_reg   <= txnKind;
                        addr_reg   <= txnAddr;
                        cmd_reg    <= txnCmd;
                        multi_reg  <= txnMulti;
                        pref_reg   <= txnPrefetch;
                        req_reg    <= txnReqDwords;
                        issueValid <= 1'b1;
                        issueAddr  <= txnAddr;
                        issueCmd   <= txnCmd;
                        state_reg  <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (attemptDone) begin
                        case (attemptTerm)
                            `BTT_TERM_RETRY: begin
                                if (attemptCount + 25'h1 >= ATTEMPT_LIMIT)
                                begin
                                    dropPulse <= 1'b1;
                                    serr_reg  <= serrAllowed(ctrl_reg,
                                                             kind_reg);
                                    stSet[`BTT_ST_SERR] <=
                                        serrAllowed(ctrl_reg, kind_reg);
                                    state_reg <= isPw ? ST_IDLE : ST_DEAD;
                                end else begin
                                    issueValid <= 1'b1;
                                    issueAddr  <= addr_reg;
                                    issueCmd   <= cmd_reg;
                                    replyValid <= ~isPw;
                                    replyRetry <= ~isPw;
                                end
                            end
                            `BTT_TERM_TABORT: begin
                                stSet[`BTT_ST_RTA] <= 1'b1;
                                stSet[`BTT_ST_STA] <= ~isPw;
                                replyValid <= ~isPw;
                                replyAbort <= ~isPw;
                                serr_reg <= isPw & ctrl_reg[`BTT_CTRL_SERR_EN]
                                            & ~ctrl_reg[`BTT_CTRL_DIS_PTA];
                                stSet[`BTT_ST_SERR] <= isPw &
                                    ctrl_reg[`BTT_CTRL_SERR_EN] &
                                    ~ctrl_reg[`BTT_CTRL_DIS_PTA];
                                state_reg <= ST_IDLE;
                            end
                            `BTT_TERM_MABORT: begin
                                stSet[`BTT_ST_RMA] <= 1'b1;
                                replyValid <= ~isPw;
                                replyTrdy  <= ~isPw &
                                              ~ctrl_reg[`BTT_CTRL_MA_MODE];
                                replyAbort <= ~isPw &
                                              ctrl_reg[`BTT_CTRL_MA_MODE];
                                stSet[`BTT_ST_STA] <= ~isPw &
                                              ctrl_reg[`BTT_CTRL_MA_MODE];
                                replyData  <= `BTT_ALL_ONES;
                                state_reg  <= ST_IDLE;
                            end
                            default: begin
                                if (isPw && postedLeft) begin
                                    addr_reg  <= addr_reg +
                                                 {22'h0, attemptDwords, 2'h0};
                                    issueValid <= 1'b1;
                                    issueAddr <= addr_reg +
                                                 {22'h0, attemptDwords, 2'h0};
                                    if (cmd_reg == `BTT_CMD_MWI &&
                                        attemptDwords != 8'h00) begin
                                        cmd_reg  <= `BTT_CMD_MEMWR;
                                        issueCmd <= `BTT_CMD_MEMWR;
                                    end else begin
                                        issueCmd <= cmd_reg;
                                    end
                                end else begin
                                    state_reg <= ST_IDLE;
                                    replyValid <= ~isPw;
                                    replyTrdy  <= ~isPw;
                                    replyData  <= 32'h00000000;
                                    replyDisc <= (isDw && multi_reg) ||
                                        (isDr && (attemptTerm ==
                                          `BTT_TERM_NORMAL) && !pref_reg) ||
                                        (isDr && req_reg > attemptDwords);
                                end
                            end
                        endcase
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // btt_termination_handler
`default_nettype wire

// File: btt_term_checker.sv
// Concurrent checks on the ports of the termination handler.
`default_nettype none
`include "btt_defs.vh"
module btt_term_checker #(
    parameter logic [24:0] ATTEMPT_LIMIT = 25'h1000000
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        clkEn,
    // Register writes
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrite,
    // Transaction and attempt result
    input wire logic        txnStart,
    input wire logic [1:0]  txnKind,
    input wire logic        txnPrefetch,
    input wire logic        attemptDone,
    input wire logic [2:0]  attemptTerm,
    input wire logic [7:0]  attemptDwords,
    input wire logic        postedLeft,
    input wire logic        initRepeat,
    // Outputs
    input wire logic        issueValid,
    input wire logic [31:0] issueAddr,
    input wire logic [3:0]  issueCmd,
    input wire logic        replyValid,
    input wire logic        replyRetry,
    input wire logic        replyDisc,
    input wire logic        replyAbort,
    input wire logic        dropPulse,
    input wire logic        serrOut
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Shadow state.
    logic [5:0]  ctrl_reg;
    logic [1:0]  kind_reg;
    logic        pref_reg;
    logic        dead_reg;
    logic [24:0] cnt_reg;
    wire retryEv = attemptDone && attemptTerm == `BTT_TERM_RETRY;
    wire atLim   = (cnt_reg + 25'h1) >= ATTEMPT_LIMIT;
    wire dly     = kind_reg != `BTT_KIND_PWRITE;
    always @(posedge core_clk) begin
        if (reset) begin
            ctrl_reg <= 6'h0;
            kind_reg <= 2'h0;
            pref_reg <= 1'h0;
            dead_reg <= 1'h0;
            cnt_reg  <= 25'h0;
        end else if (clkEn) begin
            if (regWrite && regAddr == `BTT_REG_CTRL)
                ctrl_reg <= regWrData[5:0];
            if (txnStart) begin
                kind_reg <= txnKind;
                pref_reg <= txnPrefetch;
                cnt_reg  <= 25'h0;
                dead_reg <= 1'h0;
            end else if (retryEv) begin
                cnt_reg <= cnt_reg + 25'h1;
            end
            if (retryEv && atLim && dly)
                dead_reg <= 1'h1;
            else if (initRepeat)
                dead_reg <= 1'h0;
        end
    end
    // ==========================================================
    // Assertions.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    AST_DW_RETRY: assert property (
        retryEv && kind_reg == `BTT_KIND_DWRITE && !atLim |=> issueValid
        && replyValid && replyRetry && $stable(issueAddr))
        else $error("delayed write retry not relayed and reissued");
    AST_PW_RETRY: assert property (
        retryEv && !dly && !atLim |=> issueValid && !replyValid
        && $stable(issueAddr) && $stable(issueCmd))
        else $error("posted write retry reissue wrong");
    AST_PW_DISC: assert property (
        attemptDone && attemptTerm == `BTT_TERM_DISC && !dly && postedLeft
        && !atLim |=> issueValid && issueAddr == $past(issueAddr)
        + {22'h0, $past(attemptDwords), 2'h0} && issueCmd ==
        (($past(issueCmd) == `BTT_CMD_MWI && $past(attemptDwords) != 8'h0)
        ? `BTT_CMD_MEMWR : $past(issueCmd)))
        else $error("posted write resume address or command wrong");
    AST_LIMIT_DROP: assert property (
        retryEv && atLim |=> dropPulse && !issueValid)
        else $error("attempt limit did not drop the request");
    AST_SERR_DW: assert property (
        retryEv && atLim && kind_reg == `BTT_KIND_DWRITE && ctrl_reg[0]
        && !ctrl_reg[2] |=> serrOut)
        else $error("system error missing at delayed write limit");
    AST_DLY_ABORT: assert property (
        attemptDone && attemptTerm == `BTT_TERM_TABORT && dly
        |=> replyValid && replyAbort && !issueValid)
        else $error("target abort not returned to initiator");
    AST_DEAD_ABORT: assert property (
        initRepeat && dead_reg |=> replyValid && replyAbort)
        else $error("dropped request repeat not aborted");
    AST_DR_NOPREF: assert property (
        attemptDone && attemptTerm == `BTT_TERM_NORMAL
        && kind_reg == `BTT_KIND_DREAD && !pref_reg |=> replyValid && replyDisc)
        else $error("nonprefetchable read not disconnected");
endmodule // btt_term_checker
`default_nettype wire

// File: btt_target_model.sv
// Behavioural target-bus master and target answering each issue.
`default_nettype none
`include "btt_defs.vh"
module btt_target_model (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset,
    // Issue and commanded answer
    input wire logic       issueValid,
    input wire logic       slowAnswer,
    input wire logic [2:0] nextTerm,
    input wire logic [7:0] nextDwords,
    input wire logic       nextLeft,
    // Attempt result
    output var logic       attemptDone,
    output var logic [2:0] attemptTerm,
    output var logic [7:0] attemptDwords,
    output var logic       postedLeft
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_reg;
    // Result lines toggle outside the done pulse.
    always @(posedge core_clk) begin
        if (reset) begin
            wait_reg      <= 3'h0;
            attemptDone   <= 1'h0;
            attemptTerm   <= 3'h0;
            attemptDwords <= 8'h0;
            postedLeft    <= 1'h0;
        end else begin
            attemptDone <= 1'h0;
            if (issueValid)
                wait_reg <= slowAnswer ? 3'h5 : 3'h1;
            else if (wait_reg != 3'h0)
                wait_reg <= wait_reg - 3'h1;
            if (wait_reg == 3'h1 && !issueValid) begin
                attemptDone   <= 1'h1;
                attemptTerm   <= nextTerm;
                attemptDwords <= nextDwords;
                postedLeft    <= nextLeft;
            end else begin
                attemptTerm   <= ~attemptTerm;
                attemptDwords <= ~attemptDwords;
                postedLeft    <= ~postedLeft;
            end
        end
    end
endmodule // btt_target_model
`default_nettype wire

// File: btt_termination_handler_tb_top.sv
// Self-checking bench of the termination handler.
`default_nettype none
`include "btt_defs.vh"
module btt_termination_handler_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [24:0] LIM = 25'h4;
    logic core_clk = 0, reset = 1, clkEn = 1, regWrite = 0, regRead = 0;
    logic txnStart = 0, txnMulti = 0, txnPrefetch = 0, initRepeat = 0;
    logic slowAnswer = 0, nextLeft = 0;
    logic [3:0]  regAddr = 0, txnCmd = 0;
    logic [31:0] regWrData = 0, txnAddr = 0;
    logic [1:0]  txnKind = 0;
    logic [7:0]  txnReqDwords = 0, nextDwords = 0;
    logic [2:0]  nextTerm = 0;
    logic attemptDone, postedLeft, issueValid, replyValid, replyRetry;
    logic replyDisc, replyAbort, replyTrdy, dropPulse, serrOut;
    logic [2:0]  attemptTerm;
    logic [7:0]  attemptDwords;
    logic [3:0]  issueCmd;
    logic [31:0] regRdData, issueAddr, replyData;
    int error_cnt = 0;
    int n_checks = 0;
    always #2 core_clk = ~core_clk;
    btt_termination_handler #(.ATTEMPT_LIMIT(LIM)) u_btt_termination_handler (
        .core_clk, .reset, .clkEn, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .txnStart, .txnKind, .txnAddr, .txnCmd, .txnMulti,
        .txnPrefetch, .txnReqDwords, .attemptDone, .attemptTerm,
        .attemptDwords, .postedLeft, .issueValid, .issueAddr, .issueCmd,
        .replyValid, .replyRetry, .replyDisc, .replyAbort, .replyTrdy,
        .replyData, .initRepeat, .dropPulse, .serrOut);
    btt_target_model u_btt_target_model (
        .core_clk, .reset, .issueValid, .slowAnswer, .nextTerm, .nextDwords,
        .nextLeft, .attemptDone, .attemptTerm, .attemptDwords, .postedLeft);
    // ==========================================================
    // Shared tasks.
    task automatic end_of_test;
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite <= 1; regAddr <= a; regWrData <= d;
        @(posedge core_clk);
        regWrite <= 0;
    endtask
    task automatic regRd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regRead <= 1; regAddr <= a;
        @(posedge core_clk);
        regRead <= 0;
        #1 chk(regRdData, e);
    endtask
    task automatic start(input logic [1:0] k, input logic [31:0] a,
                         input logic [3:0] c, input logic p,
                         input logic [7:0] r);
        @(posedge core_clk);
        txnStart <= 1; txnKind <= k; txnAddr <= a; txnCmd <= c;
        txnMulti <= r > 8'h1; txnPrefetch <= p; txnReqDwords <= r;
        @(posedge core_clk);
        txnStart <= 0;
        #1 chk(issueValid, 1);
        chk(issueAddr, a);
    endtask
    task automatic step(input logic [2:0] t, input logic [7:0] d,
                        input logic l, input logic s);
        int i;
        @(posedge core_clk);
        nextTerm <= t; nextDwords <= d; nextLeft <= l; slowAnswer <= s;
        #1;
        for (i = 0; i < 20 && !attemptDone; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (i == 20) begin
            error_cnt++;
            end_of_test();
        end
        @(posedge core_clk);
        #1;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic sRegs;
        regRd(`BTT_REG_CTRL, 0);
        regRd(`BTT_REG_STATUS, 0);
        regRd(4'hC, 0);
        regWr(`BTT_REG_CTRL, 1);
        regRd(`BTT_REG_CTRL, 1);
        clkEn <= 0;
        regWr(`BTT_REG_CTRL, 2);
        clkEn <= 1;
        regRd(`BTT_REG_CTRL, 1);
    endtask
    task automatic sDwRetry;
        start(`BTT_KIND_DWRITE, 32'h1000, 4'h7, 0, 8'h2);
        step(`BTT_TERM_RETRY, 0, 0, 1);
        chk({replyValid, replyRetry, issueValid}, 3'h7);
        chk(issueAddr, 32'h1000);
        step(`BTT_TERM_NORMAL, 1, 0, 0);
        chk({replyTrdy, replyDisc}, 2'h3);
    endtask
    task automatic sPosted;
        start(`BTT_KIND_PWRITE, 32'h100, `BTT_CMD_MWI, 0, 8'h8);
        step(`BTT_TERM_DISC, 3, 1, 0);
        chk(issueAddr, 32'h10C);
        chk(issueCmd, `BTT_CMD_MEMWR);
        chk(replyValid, 0);
        step(`BTT_TERM_RETRY, 0, 1, 1);
        chk(issueAddr, 32'h10C);
        step(`BTT_TERM_NORMAL, 1, 0, 0);
        chk({issueValid, replyValid}, 0);
        regWr(`BTT_REG_STATUS, 32'hF);
        start(`BTT_KIND_PWRITE, 32'h200, `BTT_CMD_MEMWR, 0, 8'h1);
        step(`BTT_TERM_TABORT, 0, 1, 0);
        chk({serrOut, replyValid}, 2'h2);
        regRd(`BTT_REG_STATUS, 32'h5);
    endtask
    task automatic one(input logic [1:0] k, input logic p,
                       input logic [7:0] r, input logic [2:0] t,
                       input logic [7:0] d, input logic [2:0] e);
        start(k, 32'h3000, 4'h6, p, r);
        step(t, d, 0, 0);
        chk({replyDisc, replyAbort, replyTrdy}, e);
    endtask
    task automatic sTable;
        regWr(`BTT_REG_STATUS, 32'hF);
        one(`BTT_KIND_DWRITE, 0, 1, `BTT_TERM_TABORT, 0, 3'h2);
        regRd(`BTT_REG_STATUS, 32'h3);
        one(`BTT_KIND_DWRITE, 0, 1, `BTT_TERM_DISC, 1, 3'h1);
        one(`BTT_KIND_DREAD, 0, 4, `BTT_TERM_NORMAL, 1, 3'h5);
        one(`BTT_KIND_DREAD, 1, 4, `BTT_TERM_NORMAL, 4, 3'h1);
        one(`BTT_KIND_DREAD, 1, 4, `BTT_TERM_DISC, 2, 3'h5);
        one(`BTT_KIND_DREAD, 1, 1, `BTT_TERM_DISC, 1, 3'h1);
        one(`BTT_KIND_DREAD, 0, 1, `BTT_TERM_TABORT, 0, 3'h2);
        one(`BTT_KIND_DREAD, 0, 1, `BTT_TERM_MABORT, 0, 3'h1);
        chk(replyData, `BTT_ALL_ONES);
        regWr(`BTT_REG_CTRL, 3);
        one(`BTT_KIND_DREAD, 0, 1, `BTT_TERM_MABORT, 0, 3'h2);
    endtask
    task automatic sLimit(input logic [1:0] k, input logic [5:0] c,
                          input logic es);
        int j;
        logic dl;
        dl = k != `BTT_KIND_PWRITE;
        regWr(`BTT_REG_CTRL, {26'h0, c});
        regWr(`BTT_REG_STATUS, 32'hF);
        start(k, 32'h2000, 4'h7, 0, 8'h1);
        for (j = 1; j < LIM; j++) begin
            step(`BTT_TERM_RETRY, 0, 1, 0);
            chk({issueValid, replyValid, dropPulse}, {1'h1, dl, 1'h0});
        end
        step(`BTT_TERM_RETRY, 0, 1, 0);
        chk({dropPulse, issueValid, serrOut}, {2'h2, es});
        if (dl) begin
            @(posedge core_clk);
            initRepeat <= 1;
            @(posedge core_clk);
            initRepeat <= 0;
            #1 chk({replyValid, replyAbort}, 2'h3);
        end
        regRd(`BTT_REG_STATUS, {29'h0, es, dl, 1'h0});
        regRd(`BTT_REG_COUNT, {7'h0, LIM});
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 0;
        sRegs();
        sDwRetry();
        sPosted();
        sTable();
        sLimit(`BTT_KIND_DWRITE, 6'h01, 1);
        sLimit(`BTT_KIND_DWRITE, 6'h05, 0);
        sLimit(`BTT_KIND_PWRITE, 6'h01, 1);
        sLimit(`BTT_KIND_DREAD, 6'h01, 1);
        sLimit(`BTT_KIND_DREAD, 6'h11, 0);
        end_of_test();
    end
endmodule // btt_termination_handler_tb_top
bind btt_termination_handler btt_term_checker #(
    .ATTEMPT_LIMIT(ATTEMPT_LIMIT)) u_btt_term_checker (
    .core_clk, .reset, .regAddr, .regWrData, .regWrite, .txnStart, .txnKind,
    .txnPrefetch, .attemptDone, .attemptTerm, .attemptDwords, .postedLeft,
    .initRepeat, .issueValid, .issueAddr, .issueCmd, .replyValid,
    .replyRetry, .replyDisc, .replyAbort, .dropPulse, .serrOut, .clkEn);
`default_nettype wire
